// ---- hdl/capture_input_pkg.sv ----
// constants for the timer capture input stage: offsets, fields, select codes and the dead-time divider
// assumes a plain register port with read data one cycle after the read strobe
package capture_input_pkg;
    localparam logic [7:0] MODE_CH1_CH2_OFFSET = 8'h18;
    localparam logic [7:0] MODE_CH3_CH4_OFFSET = 8'h1C;
    localparam logic [7:0] CHAN_ENABLE_OFFSET = 8'h20;
    localparam logic [7:0] CAPTURE_STATUS_OFFSET = 8'h34;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    localparam logic [15:0] MODE_WRITE_MASK = 16'hFFFF;
    localparam int CH_FIELD_WIDTH = 8;
    localparam int SEL_LSB = 0;
    localparam int DIV_LSB = 2;
    localparam int FILT_LSB = 4;
    localparam int ENABLE_STRIDE = 4;
    localparam logic [1:0] SEL_OUTPUT = 2'h0;
    localparam logic [1:0] SEL_OWN = 2'h1;
    localparam logic [1:0] SEL_NEIGHBOUR = 2'h2;
    localparam logic [1:0] SEL_TRIGGER = 2'h3;
    // dead-time clock divider from the timer clock, chosen as 1
    localparam logic [7:0] DTS_DIV = 8'h01;
    localparam int NUM_CH = 4;
endpackage : capture_input_pkg

// ---- hdl/timer_capture_input_stage.sv ----
// four-channel capture input stage: synchroniser, filter, edge detect, event divider
// each channel runs pin or trigger, then filter, then edge detect, then divider
// assumes asynchronous timer input pins and an internal trigger on core_clk
// assumes the trigger already lives on core_clk, so it skips the synchroniser
// assumes software keeps select writes away from enabled channels
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
module timer_capture_input_stage
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // timer inputs and trigger
    input wire logic [3:0] timer_input,
    input wire logic internal_trigger_signal,
    // capture results
    output logic [3:0] capture_event,
    output logic [3:0] filtered_input,
    output logic [3:0] channel_is_input
);

    // filter code decode, shared by every channel
    // filter sample period (in dts ticks, 1 means every dts tick) and count
    // the period counts dts ticks, so it scales with the dead-time divider
    // filter codes 1-3 sample every timer clock and ignore the period
    function automatic logic [5:0] filt_period(input logic [3:0] code);
        case (code)
            4'h4, 4'h5: filt_period = 6'h02;
            4'h6, 4'h7: filt_period = 6'h04;
            4'h8, 4'h9: filt_period = 6'h08;
            4'hA, 4'hB, 4'hC: filt_period = 6'h10;
            4'hD, 4'hE, 4'hF: filt_period = 6'h20;
            default: filt_period = 6'h01;
        endcase
    endfunction : filt_period

    // samples in a row that must differ from the filtered level before it moves
    // code 0 moves on a single sample, so only the synchroniser and filter register delay remain
    function automatic logic [3:0] filt_count(input logic [3:0] code);
        case (code)
            4'h1: filt_count = 4'h2;
            4'h2: filt_count = 4'h4;
            4'h4, 4'h6, 4'h8, 4'hB, 4'hE: filt_count = 4'h6;
            4'hA, 4'hD: filt_count = 4'h5;
            4'h0: filt_count = 4'h1;
            default: filt_count = 4'h8;
        endcase
    endfunction : filt_count

    // a channel counts as an input whenever its select field is not output
    function automatic logic sel_is_input(input logic [1:0] s);
        sel_is_input = (s != capture_input_pkg::SEL_OUTPUT);
    endfunction : sel_is_input

    // the divider lets a capture through once the count has filled its mask
    function automatic logic capture_due(input logic [2:0] cnt, input logic [2:0] mask);
        capture_due = ((cnt & mask) == mask);
    endfunction : capture_due

    // mode, enable and status registers
    logic [15:0] mode12_q;
    logic [15:0] mode34_q;
    logic [15:0] enable_q;
    logic [3:0] cap_seen_q;
    // dead-time tick
    logic [7:0] dts_cnt_q;
    logic dts_tick;
    // synchroniser stages
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    // field views
    logic [31:0] mode_both;
    logic [3:0] ch_en;

    // write strobes
    logic wr_mode12;
    logic wr_mode34;
    logic wr_enable;
    logic wr_status;

    // register port write decode, one strobe per register
    assign wr_mode12 = reg_write && (reg_addr == capture_input_pkg::MODE_CH1_CH2_OFFSET);
    assign wr_mode34 = reg_write && (reg_addr == capture_input_pkg::MODE_CH3_CH4_OFFSET);
    assign wr_enable = reg_write && (reg_addr == capture_input_pkg::CHAN_ENABLE_OFFSET);
    assign wr_status = reg_write && (reg_addr == capture_input_pkg::CAPTURE_STATUS_OFFSET);

    // both mode registers side by side, channel n in byte n-1
    assign mode_both = {mode34_q, mode12_q};

    // dead-time sampling tick
    // with a divider of one the tick is high on every timer clock
    always_ff @(posedge core_clk)
    begin
        if (!rst_b || dts_cnt_q == capture_input_pkg::DTS_DIV - 8'h01)
            dts_cnt_q <= 8'h00;
        else
            dts_cnt_q <= dts_cnt_q + 8'h01;
    end
    assign dts_tick = (dts_cnt_q == 8'h00);

    // two-flop synchroniser for the pins
    // nothing but the second stage reads the first, to keep metastability contained
    // the stages reset low like an idle pin, so release gives no false level change
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end
        else
        begin
            sync1_q <= timer_input;
            sync2_q <= sync1_q;
        end
    end

    // mode register writes; select field held while channel enabled
    // per channel byte: [1:0] select, [3:2] event divider, [7:4] filter code
    // freezing the select keeps routing from shifting under a live capture
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            // both mode registers and the enables come up zero
            mode12_q <= capture_input_pkg::MODE_RESET[15:0];
            mode34_q <= capture_input_pkg::MODE_RESET[15:0];
            enable_q <= 16'h0000;
        end
        else if (reg_write)
        begin
            // channel 1 in the low byte, channel 2 in the high byte
            if (wr_mode12)
            begin
                mode12_q[7:2] <= reg_wdata[7:2];
                mode12_q[15:10] <= reg_wdata[15:10];
                if (!ch_en[0])
                    mode12_q[1:0] <= reg_wdata[1:0];
                if (!ch_en[1])
                    mode12_q[9:8] <= reg_wdata[9:8];
            end
            // channel 3 in the low byte, channel 4 in the high byte
            if (wr_mode34)
            begin
                mode34_q[7:2] <= reg_wdata[7:2];
                mode34_q[15:10] <= reg_wdata[15:10];
                if (!ch_en[2])
                    mode34_q[1:0] <= reg_wdata[1:0];
                if (!ch_en[3])
                    mode34_q[9:8] <= reg_wdata[9:8];
            end
            // one enable bit per channel, every fourth bit
            if (wr_enable)
                enable_q <= reg_wdata[15:0];
        end
    end

    // per-channel filter, edge detect and event divider
    // pin to capture pulse: two synchroniser stages, the filter, then the
    // edge decoded straight off the filter and one register for the pulse; the trigger skips the
    // synchroniser, being on this clock already
    genvar g;
    generate
        for (g = 0; g < capture_input_pkg::NUM_CH; g++)
        begin : g_ch
            // per-channel decode and state
            logic [7:0] fld;
            logic [1:0] sel;
            logic [1:0] div;
            logic [3:0] fcode;
            logic src;
            logic filt_q;
            logic filt_prev_q;
            logic [3:0] run_q;
            logic [5:0] per_q;
            logic sample;
            logic edge_seen;
            logic [2:0] evt_q;
            logic [2:0] evt_mask;
            logic due;

            // field decode for this channel
            assign ch_en[g] = enable_q[g * capture_input_pkg::ENABLE_STRIDE];
            assign fld = mode_both[g * capture_input_pkg::CH_FIELD_WIDTH +: capture_input_pkg::CH_FIELD_WIDTH];
            assign sel = fld[capture_input_pkg::SEL_LSB +: 2];
            assign div = fld[capture_input_pkg::DIV_LSB +: 2];
            assign fcode = fld[capture_input_pkg::FILT_LSB +: 4];

            // input routing; the neighbour select takes the other channel of the pair, in both directions
            // select 00 feeds a steady low, so an output channel never sees an edge
            always_comb
            begin
                case (sel)
                    capture_input_pkg::SEL_OWN: src = sync2_q[g];
                    capture_input_pkg::SEL_NEIGHBOUR: src = sync2_q[g ^ 1];
                    capture_input_pkg::SEL_TRIGGER: src = internal_trigger_signal;
                    default: src = 1'b0;
                endcase
            end

            // sample strobe: timer clock for codes 1-3, dts otherwise
            // codes 4-15 fire once per period, on its last dts tick
            always_comb
            begin
                if (fcode == 4'h0)
                    sample = dts_tick;
                else if (fcode <= 4'h3)
                    sample = 1'b1;
                else
                    sample = dts_tick && (per_q == filt_period(fcode) - 6'h01);
            end

            // divided-dts phase counter
            // held at zero on codes 0-3 so a slow code starts in phase when entered from codes 0-3
            always_ff @(posedge core_clk)
            begin
                if (!rst_b || fcode <= 4'h3)
                    per_q <= 6'h00;
                else if (dts_tick)
                begin
                    if (per_q == filt_period(fcode) - 6'h01)
                        per_q <= 6'h00;
                    else
                        per_q <= per_q + 6'h01;
                end
            end

            // consecutive-sample event counter
            // a sample equal to the filtered level restarts the run, so a
            // glitch shorter than N samples never reaches the edge detector
            always_ff @(posedge core_clk)
            begin
                if (!rst_b)
                begin
                    filt_q <= 1'b0;
                    run_q <= 4'h0;
                end
                else if (sample)
                begin
                    if (src == filt_q)
                        run_q <= 4'h0;
                    else if (run_q + 4'h1 >= filt_count(fcode))
                    begin
                        filt_q <= src;
                        run_q <= 4'h0;
                    end
                    else
                        run_q <= run_q + 4'h1;
                end
            end

            // edge detection on the filtered level
            // the previous level resets low like the idle pin, so reset gives no false edge
            always_ff @(posedge core_clk)
            begin
                if (!rst_b)
                    filt_prev_q <= 1'b0;
                else
                    filt_prev_q <= filt_q;
            end
            // only channels set as inputs report edges
            assign edge_seen = (filt_q != filt_prev_q) && sel_is_input(sel);

            // event divider mask per code
            // mask 1, 3 or 7 lets every 2nd, 4th or 8th counted edge through
            always_comb
            begin
                case (div)
                    2'h1: evt_mask = 3'h1;
                    2'h2: evt_mask = 3'h3;
                    2'h3: evt_mask = 3'h7;
                    default: evt_mask = 3'h0;
                endcase
            end
            // the divider is due when the count has run through its mask
            assign due = capture_due(evt_q, evt_mask);

            // event counter, held at zero while the channel is off
            // the count only advances on edges the filter has passed
            always_ff @(posedge core_clk)
            begin
                if (!rst_b || !ch_en[g])
                    evt_q <= 3'h0;
                else if (edge_seen)
                begin
                    if (due)
                        evt_q <= 3'h0;
                    else
                        evt_q <= evt_q + 3'h1;
                end
            end

            // capture pulse, registered
            // a capture stands for exactly one clock
            always_ff @(posedge core_clk)
            begin
                if (!rst_b)
                    capture_event[g] <= 1'b0;
                else
                    capture_event[g] <= ch_en[g] && edge_seen && due;
            end

            // outputs of this channel
            assign filtered_input[g] = filt_q;
            assign channel_is_input[g] = sel_is_input(sel);
        end
    endgenerate

    // sticky capture-seen bits; new capture wins over clear
    // write one to clear; a pulse in the clearing cycle still sets its bit
    // status bit n-1 follows channel n
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            cap_seen_q <= 4'h0;
        else if (wr_status)
            cap_seen_q <= (cap_seen_q & ~reg_wdata[3:0]) | capture_event;
        else
            cap_seen_q <= cap_seen_q | capture_event;
    end

    // read data one cycle after the strobe; unmapped reads zero
    // without a strobe the port reads zero, so stale data never shows
    // status reads as filtered levels in [7:4] over the sticky bits in [3:0]
    always_ff @(posedge core_clk)
    begin
        if (!rst_b || !reg_read)
            reg_rdata <= 32'h0000_0000;
        else
        begin
            case (reg_addr)
                capture_input_pkg::MODE_CH1_CH2_OFFSET: reg_rdata <= {16'h0000, mode12_q};
                capture_input_pkg::MODE_CH3_CH4_OFFSET: reg_rdata <= {16'h0000, mode34_q};
                capture_input_pkg::CHAN_ENABLE_OFFSET: reg_rdata <= {16'h0000, enable_q};
                capture_input_pkg::CAPTURE_STATUS_OFFSET: reg_rdata <= {24'h000000, filtered_input, cap_seen_q};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule : timer_capture_input_stage

// ---- tb/capture_input_asserts.sv ----
// port-level checks for the capture input stage
// assumes the design package is compiled first; bound to the top module below
`timescale 1ns/10ps
module capture_input_asserts
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    // pins and results
    input wire logic [3:0] timer_input,
    input wire logic internal_trigger_signal,
    input wire logic [3:0] capture_event,
    input wire logic [3:0] filtered_input,
    input wire logic [3:0] channel_is_input
);
    logic [3:0] en_q;
    logic [7:0] mode_q;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // shadow of the enables and of the channel one mode byte
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            en_q <= 4'h0;
            mode_q <= 8'h00;
        end
        else if (reg_write && reg_addr == capture_input_pkg::CHAN_ENABLE_OFFSET)
            en_q <= {reg_wdata[12], reg_wdata[8], reg_wdata[4], reg_wdata[0]};
        else if (reg_write && reg_addr == capture_input_pkg::MODE_CH1_CH2_OFFSET)
            mode_q <= {reg_wdata[7:2], en_q[0] ? mode_q[1:0] : reg_wdata[1:0]};
    end
    mode_upper_zero_a: assert property (reg_read && reg_addr == 8'h1C |=> reg_rdata[31:16] == 16'h0000)
        else $error("upper mode bits not zero");
    sel_write_taken_a: assert property (reg_write && reg_addr == 8'h18 && !en_q[0]
        |=> channel_is_input[0] == (($past(reg_wdata) & 32'h3) != 32'h0)) else $error("direction not taken");
    sel_write_locked_a: assert property (reg_write && reg_addr == 8'h18 && en_q[0]
        |=> $stable(channel_is_input[0])) else $error("direction changed while enabled");
    edge_feeds_capture_a: assert property (capture_event[0]
        |-> $past(filtered_input[0]) != $past(filtered_input[0], 2)) else $error("capture without filtered edge");
    capture_needs_input_a: assert property (capture_event[0] |-> $past(channel_is_input[0]))
        else $error("capture on output channel");
    every_edge_captured_a: assert property (mode_q[3:2] == 2'h0 && mode_q[1:0] != 2'h0 && en_q[0]
        && $changed(filtered_input[0]) |=> capture_event[0]) else $error("edge not captured");
    no_filter_lag_a: assert property (mode_q == 8'h01 && $changed(filtered_input[0])
        |-> $past(timer_input[0], 3) == filtered_input[0]) else $error("unfiltered path latency wrong");
    two_sample_filter_a: assert property (mode_q[7:4] == 4'h1 && mode_q[1:0] == 2'h1
        && $changed(filtered_input[0]) |-> $past(timer_input[0], 3) == filtered_input[0]
        && $past(timer_input[0], 4) == filtered_input[0]) else $error("short pulse passed filter");
    // main scenarios
    cover property (capture_event[0] && mode_q[3:2] != 2'h0);
    cover property (capture_event[0] && mode_q[1:0] == capture_input_pkg::SEL_TRIGGER);
    cover property (capture_event[2] && capture_event[3]);
endmodule : capture_input_asserts
bind timer_capture_input_stage capture_input_asserts u_asserts (.core_clk(core_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .timer_input(timer_input), .internal_trigger_signal(internal_trigger_signal),
    .capture_event(capture_event), .filtered_input(filtered_input), .channel_is_input(channel_is_input));

// ---- tb/pin_source.sv ----
// far-side model: drives the timer input pins and the internal trigger
// assumes level requests from the bench, applied at the rising clock edge
`timescale 1ns/10ps
module pin_source
#(
    parameter logic TRIGGER_SELECTED = 1'b1
)
(
    // clock
    input wire logic core_clk,
    // requested levels, bit 4 is the trigger
    input wire logic [4:0] pin_req,
    // driven pins
    output logic [3:0] timer_input,
    output logic internal_trigger_signal
);
    // pins start low, then move just after each edge
    initial timer_input = 4'h0;
    initial internal_trigger_signal = 1'b0;
    always @(posedge core_clk)
    begin
        timer_input <= pin_req[3:0];
        // trigger reaches the channel only with a trigger source selected
        internal_trigger_signal <= pin_req[4] & TRIGGER_SELECTED;
    end
endmodule : pin_source

// ---- tb/testbench.sv ----
// self-checking bench: register tasks, pin toggling and capture counts
// assumes the design package, design, checker and pin model are compiled first
`timescale 1ns/10ps
module testbench;
    localparam logic [7:0] MODE12 = capture_input_pkg::MODE_CH1_CH2_OFFSET;
    localparam logic [7:0] MODE34 = capture_input_pkg::MODE_CH3_CH4_OFFSET;
    localparam logic [7:0] ENA = capture_input_pkg::CHAN_ENABLE_OFFSET;
    logic core_clk;
    logic rst_b;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_write;
    logic reg_read;
    logic [31:0] reg_rdata;
    logic [4:0] pin_req;
    logic [3:0] timer_input;
    logic internal_trigger_signal;
    logic [3:0] capture_event;
    logic [3:0] filtered_input;
    logic [3:0] channel_is_input;
    int fails;
    int checks_done;
    int caps [4];
    int code_tab [5] = '{1, 2, 3, 4, 13};
    int rej_tab [5] = '{1, 3, 7, 10, 128};
    int pass_tab [5] = '{3, 5, 9, 14, 192};
    timer_capture_input_stage dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .timer_input(timer_input),
        .internal_trigger_signal(internal_trigger_signal), .capture_event(capture_event),
        .filtered_input(filtered_input), .channel_is_input(channel_is_input));
    pin_source partner (.core_clk(core_clk), .pin_req(pin_req), .timer_input(timer_input),
        .internal_trigger_signal(internal_trigger_signal));
    // clock generator
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // capture pulse counters
    always @(posedge core_clk)
        for (int i = 0; i < 4; i++)
            if (capture_event[i] === 1'b1)
                caps[i]++;
    task report_and_stop;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask : rd
    // toggles one request bit n times, w cycles apart, then compares all capture counts
    task caps_check(input int pin, input int n, input int w, input logic [15:0] exp);
        int base [4];
        base = caps;
        repeat (n)
        begin
            @(posedge core_clk);
            pin_req[pin] <= ~pin_req[pin];
            repeat (w - 1) @(posedge core_clk);
        end
        repeat (w + 24) @(posedge core_clk);
        for (int i = 0; i < 4; i++)
            check(32'(caps[i] - base[i]), {28'h0, exp[4 * i +: 4]});
    endtask : caps_check
    // watchdog
    initial
    begin
        repeat (10000) @(posedge core_clk);
        fails++;
        report_and_stop();
    end
    // main sequence
    initial
    begin
        rst_b = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        pin_req = 5'h00;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(MODE34, 32'h0);
        rd(8'h40, 32'h0);
        wr(MODE12, 32'h0201);
        wr(ENA, 32'h11);
        caps_check(0, 4, 6, 16'h0044);
        rd(capture_input_pkg::CAPTURE_STATUS_OFFSET, 32'h3);
        wr(capture_input_pkg::CAPTURE_STATUS_OFFSET, 32'hF);
        rd(capture_input_pkg::CAPTURE_STATUS_OFFSET, 32'h0);
        caps_check(1, 2, 6, 16'h0000);
        for (int d = 1; d < 4; d++)
        begin
            wr(ENA, 32'h0);
            wr(MODE12, 32'(1 + 4 * d));
            wr(ENA, 32'h1);
            caps_check(0, 8, 6, 16'(8 >> d));
        end
        wr(ENA, 32'h0);
        wr(MODE12, 32'h9);
        wr(ENA, 32'h1);
        caps_check(0, 3, 6, 16'h0);
        wr(ENA, 32'h0);
        wr(ENA, 32'h1);
        caps_check(0, 1, 6, 16'h0);
        for (int k = 0; k < 5; k++)
        begin
            wr(ENA, 32'h0);
            wr(MODE12, 32'(code_tab[k] * 16 + 1));
            wr(ENA, 32'h1);
            caps_check(0, 2, rej_tab[k], 16'h0);
            caps_check(0, 2, pass_tab[k], 16'h2);
        end
        wr(MODE12, 32'h0);
        rd(MODE12, 32'h1);
        wr(ENA, 32'h0);
        wr(MODE12, 32'h0);
        #1 check(channel_is_input, 32'h0);
        wr(ENA, 32'h1);
        caps_check(0, 2, 6, 16'h0);
        wr(ENA, 32'h0);
        wr(MODE12, 32'h3);
        wr(ENA, 32'h1);
        caps_check(4, 2, 6, 16'h2);
        wr(MODE34, 32'h0102);
        rd(MODE34, 32'h0102);
        wr(ENA, 32'h1100);
        caps_check(3, 2, 6, 16'h2200);
        report_and_stop();
    end
endmodule : testbench
